// [core/fnmt_slave.sv]
// design: network management slave state machine, service gating and identifier map
`timescale 1ns/1ps
module fnmt_slave
    import fnmt_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic [6:0] node_id,
    input wire logic rx_valid,
    input wire logic [10:0] rx_id,
    input wire logic rx_ext,
    input wire logic [3:0] rx_len,
    input wire logic [7:0] rx_b0,
    input wire logic [7:0] rx_b1,
    input wire logic obj_wr,
    input wire logic [15:0] obj_index,
    input wire logic [7:0] obj_sub,
    input wire logic [31:0] obj_data,
    input wire logic obj_savable,
    input wire logic save_done,
    output logic [1:0] nmt_state,
    output logic node_rst_req,
    output logic comm_rst_req,
    output logic boot_send,
    output logic pdo_en,
    output logic sdo_en,
    output logic sync_en,
    output logic emcy_en,
    output logic node_ok,
    output logic [2:0] rx_svc,
    output logic rx_hit,
    output logic [10:0] id_sdo_tx,
    output logic [10:0] id_sdo_rx,
    output logic [10:0] id_emcy,
    output logic [10:0] id_boot,
    output logic [43:0] id_tpdo,
    output logic [43:0] id_rpdo,
    output logic [31:0] marker_date,
    output logic [31:0] marker_time,
    output logic [31:0] save_sub1,
    output logic save_start
);
    // --------------------------------------------------------------
    // frame decode
    // --------------------------------------------------------------
    fnmt_state_e state_r;
    logic [3:0] init_cnt_r;
    logic nmt_frame;
    logic nmt_addr;
    logic cmd_known;
    logic [10:0] nid;

    assign nid = {4'h0, node_id};
    assign nmt_frame = rx_valid && !rx_ext && rx_id == FNMT_ID_NMT
        && rx_len == FNMT_NMT_LEN;
    assign nmt_addr = rx_b1 == FNMT_NODE_ALL || rx_b1 == {1'b0, node_id};
    assign cmd_known = rx_b0 == FNMT_CMD_OPER || rx_b0 == FNMT_CMD_STOP
        || rx_b0 == FNMT_CMD_PREOP || rx_b0 == FNMT_CMD_RST_NODE
        || rx_b0 == FNMT_CMD_RST_COMM;

    logic take_cmd;
    assign take_cmd = nmt_frame && nmt_addr && cmd_known && node_ok
        && state_r != FNMT_ST_INIT;

    // --------------------------------------------------------------
    // state machine
    // --------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            state_r <= FNMT_ST_INIT;
            init_cnt_r <= FNMT_INIT_CNT;
        end else begin
            case (state_r)
                FNMT_ST_INIT: begin
                    if (init_cnt_r == 4'h0) begin
                        state_r <= FNMT_ST_PREOP;
                    end else begin
                        init_cnt_r <= init_cnt_r - 4'h1;
                    end
                end
                FNMT_ST_PREOP, FNMT_ST_OPER, FNMT_ST_STOP: begin
                    if (take_cmd) begin
                        case (rx_b0)
                            FNMT_CMD_OPER: state_r <= FNMT_ST_OPER;
                            FNMT_CMD_STOP: state_r <= FNMT_ST_STOP;
                            FNMT_CMD_PREOP: state_r <= FNMT_ST_PREOP;
                            default: begin
                                state_r <= FNMT_ST_INIT;
                                init_cnt_r <= FNMT_INIT_CNT;
                            end
                        endcase
                    end
                end
                default: state_r <= FNMT_ST_INIT;
            endcase
        end
    end

    // resets are only requested; the system reset and comm settings live outside
    always_ff @(posedge mclk) begin
        if (srst) begin
            node_rst_req <= 1'b0;
            comm_rst_req <= 1'b0;
        end else begin
            node_rst_req <= take_cmd && rx_b0 == FNMT_CMD_RST_NODE;
            comm_rst_req <= take_cmd && rx_b0 == FNMT_CMD_RST_COMM;
        end
    end

    // --------------------------------------------------------------
    // service gating
    // --------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            nmt_state <= 2'b00;
            pdo_en <= 1'b0;
            sdo_en <= 1'b0;
            sync_en <= 1'b0;
            emcy_en <= 1'b0;
            boot_send <= 1'b0;
            node_ok <= 1'b0;
        end else begin
            nmt_state <= state_r;
            node_ok <= node_id >= FNMT_NODE_MIN;
            pdo_en <= state_r == FNMT_ST_OPER;
            sdo_en <= state_r == FNMT_ST_PREOP || state_r == FNMT_ST_OPER;
            sync_en <= state_r == FNMT_ST_PREOP || state_r == FNMT_ST_OPER;
            emcy_en <= state_r == FNMT_ST_PREOP || state_r == FNMT_ST_OPER;
            // one boot-up announcement on leaving initialization, only while node_ok is set
            boot_send <= state_r == FNMT_ST_INIT && init_cnt_r == 4'h0 && node_ok;
        end
    end

    // --------------------------------------------------------------
    // identifier map
    // --------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (srst) begin
            id_sdo_tx <= 11'h000;
            id_sdo_rx <= 11'h000;
            id_emcy <= 11'h000;
            id_boot <= 11'h000;
            id_tpdo <= 44'h0;
            id_rpdo <= 44'h0;
        end else begin
            id_sdo_tx <= FNMT_BASE_SDO_TX + nid;
            id_sdo_rx <= FNMT_BASE_SDO_RX + nid;
            id_emcy <= FNMT_BASE_EMCY + nid;
            id_boot <= FNMT_BASE_BOOT + nid;
            id_tpdo <= {FNMT_BASE_TPD4 + nid, FNMT_BASE_TPD3 + nid,
                FNMT_BASE_TPD2 + nid, FNMT_BASE_TPD1 + nid};
            id_rpdo <= {FNMT_BASE_RPD4 + nid, FNMT_BASE_RPD3 + nid,
                FNMT_BASE_RPD2 + nid, FNMT_BASE_RPD1 + nid};
        end
    end

    // received frame class: 1 nmt, 2 sync, 3 sdo request, 4 process data in; 0 none
    logic [2:0] svc_nxt;
    always_comb begin
        svc_nxt = 3'd0;
        if (rx_valid && !rx_ext) begin
            if (rx_id == FNMT_ID_NMT) begin
                svc_nxt = 3'd1;
            end else if (rx_id == FNMT_ID_SYNC && sync_en) begin
                svc_nxt = 3'd2;
            end else if (rx_id == id_sdo_rx && sdo_en) begin
                svc_nxt = 3'd3;
            end else if (pdo_en && (rx_id == id_rpdo[10:0] || rx_id == id_rpdo[21:11]
                || rx_id == id_rpdo[32:22] || rx_id == id_rpdo[43:33])) begin
                svc_nxt = 3'd4;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            rx_svc <= 3'd0;
            rx_hit <= 1'b0;
        end else begin
            rx_svc <= svc_nxt;
            rx_hit <= svc_nxt != 3'd0;
        end
    end

    // --------------------------------------------------------------
    // modification marker and save
    // --------------------------------------------------------------
    logic wr_marker;
    logic wr_save_all;
    assign wr_marker = obj_wr && obj_index == FNMT_OBJ_MARKER;
    assign wr_save_all = obj_wr && obj_index == FNMT_OBJ_SAVE && obj_sub == FNMT_SUB_SAVE_ALL;

    always_ff @(posedge mclk) begin
        if (srst) begin
            marker_date <= FNMT_MARK_RESET;
            marker_time <= FNMT_MARK_RESET;
        end else if (wr_marker) begin
            // object data arrives already assembled lsb first
            if (obj_sub == 8'h01) begin
                marker_date <= obj_data;
            end else if (obj_sub == 8'h02) begin
                marker_time <= obj_data;
            end
        end else if (obj_wr && !wr_save_all
            && (obj_savable || obj_index == FNMT_OBJ_SAVE)) begin
            marker_date <= FNMT_MARK_RESET;
            marker_time <= FNMT_MARK_RESET;
        end
    end

    // done wins over a new write in the same cycle: the save then really finished
    always_ff @(posedge mclk) begin
        if (srst) begin
            save_sub1 <= FNMT_SAVE_DONE;
            save_start <= 1'b0;
        end else begin
            save_start <= wr_save_all && obj_data == FNMT_SAVE_KEY;
            if (save_done) begin
                save_sub1 <= FNMT_SAVE_DONE;
            end else if (wr_save_all) begin
                save_sub1 <= obj_data;
            end
        end
    end

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    property p_stop_quiet;
        @(posedge mclk) disable iff (srst)
        state_r == FNMT_ST_STOP |=> !pdo_en && !sdo_en && !sync_en && !emcy_en;
    endproperty
    a_stop_quiet: assert property (p_stop_quiet) else $error("service on in stopped");

    property p_init_leaves;
        @(posedge mclk) disable iff (srst)
        $rose(state_r == FNMT_ST_INIT) |-> ##[1:12] state_r == FNMT_ST_PREOP;
    endproperty
    a_init_leaves: assert property (p_init_leaves) else $error("init did not end");

    property p_cmd_oper;
        @(posedge mclk) disable iff (srst)
        take_cmd && rx_b0 == FNMT_CMD_OPER |=> state_r == FNMT_ST_OPER ##1 pdo_en;
    endproperty
    a_cmd_oper: assert property (p_cmd_oper) else $error("start command lost");

    property p_bad_len;
        @(posedge mclk) disable iff (srst)
        rx_valid && rx_id == FNMT_ID_NMT && rx_len != FNMT_NMT_LEN
            && state_r != FNMT_ST_INIT |=> $stable(state_r);
    endproperty
    a_bad_len: assert property (p_bad_len) else $error("short frame changed state");

    property p_other_node;
        @(posedge mclk) disable iff (srst)
        nmt_frame && rx_b1 != 8'h00 && rx_b1 != {1'b0, node_id} && state_r != FNMT_ST_INIT
            |=> $stable(state_r);
    endproperty
    a_other_node: assert property (p_other_node) else $error("acted for other node");

    property p_init_entry;
        @(posedge mclk) disable iff (srst)
        $rose(state_r == FNMT_ST_INIT) |-> node_rst_req || comm_rst_req;
    endproperty
    a_init_entry: assert property (p_init_entry) else $error("init without reset");

    property p_sdo_id;
        @(posedge mclk) disable iff (srst)
        ##2 1'b1 |-> id_sdo_rx - id_sdo_tx == 11'h080 && id_tpdo[10:0] == id_emcy + 11'h100;
    endproperty
    a_sdo_id: assert property (p_sdo_id) else $error("identifier map wrong");

    property p_mark_clr;
        @(posedge mclk) disable iff (srst)
        obj_wr && obj_savable && !wr_marker && !wr_save_all |=> marker_date == 32'h0000_0000;
    endproperty
    a_mark_clr: assert property (p_mark_clr) else $error("marker not cleared");

    property p_save_done;
        @(posedge mclk) disable iff (srst)
        save_done |=> save_sub1 == 32'h0000_0001;
    endproperty
    a_save_done: assert property (p_save_done) else $error("save not signalled");
endmodule

// [core/fnmt_pkg.sv]
// package: constants for the fieldbus network management slave and identifier map
package fnmt_pkg;
    // --------------------------------------------------------------
    // identifiers
    // --------------------------------------------------------------
    localparam logic [10:0] FNMT_ID_NMT = 11'h000;
    localparam logic [10:0] FNMT_ID_SYNC = 11'h080;
    localparam logic [10:0] FNMT_BASE_EMCY = 11'h080;
    localparam logic [10:0] FNMT_BASE_TPD1 = 11'h180;
    localparam logic [10:0] FNMT_BASE_RPD1 = 11'h200;
    localparam logic [10:0] FNMT_BASE_TPD2 = 11'h280;
    localparam logic [10:0] FNMT_BASE_RPD2 = 11'h300;
    localparam logic [10:0] FNMT_BASE_TPD3 = 11'h380;
    localparam logic [10:0] FNMT_BASE_RPD3 = 11'h400;
    localparam logic [10:0] FNMT_BASE_TPD4 = 11'h480;
    localparam logic [10:0] FNMT_BASE_RPD4 = 11'h500;
    localparam logic [10:0] FNMT_BASE_SDO_TX = 11'h580;
    localparam logic [10:0] FNMT_BASE_SDO_RX = 11'h600;
    localparam logic [10:0] FNMT_BASE_BOOT = 11'h700;
    // --------------------------------------------------------------
    // commands and node ids
    // --------------------------------------------------------------
    localparam logic [7:0] FNMT_CMD_OPER = 8'h01;
    localparam logic [7:0] FNMT_CMD_STOP = 8'h02;
    localparam logic [7:0] FNMT_CMD_PREOP = 8'h80;
    localparam logic [7:0] FNMT_CMD_RST_NODE = 8'h81;
    localparam logic [7:0] FNMT_CMD_RST_COMM = 8'h82;
    localparam logic [7:0] FNMT_NODE_ALL = 8'h00;
    localparam logic [6:0] FNMT_NODE_MIN = 7'h01;
    localparam logic [3:0] FNMT_NMT_LEN = 4'h2;
    // --------------------------------------------------------------
    // object access
    // --------------------------------------------------------------
    localparam logic [15:0] FNMT_OBJ_MARKER = 16'h1020;
    localparam logic [15:0] FNMT_OBJ_SAVE = 16'h1010;
    localparam logic [7:0] FNMT_SUB_SAVE_ALL = 8'h01;
    localparam logic [31:0] FNMT_SAVE_KEY = 32'h6576_6173;
    localparam logic [31:0] FNMT_SAVE_DONE = 32'h0000_0001;
    localparam logic [31:0] FNMT_MARK_RESET = 32'h0000_0000;
    // --------------------------------------------------------------
    // timing
    // --------------------------------------------------------------
    localparam int FNMT_INIT_NS = 200;
    localparam int FNMT_CLK_NS = 20;
    localparam int FNMT_INIT_CYC = (FNMT_INIT_NS + FNMT_CLK_NS - 1) / FNMT_CLK_NS;
    localparam logic [3:0] FNMT_INIT_CNT = 4'(FNMT_INIT_CYC);

    typedef enum logic [1:0] {
        FNMT_ST_INIT = 2'b00,
        FNMT_ST_PREOP = 2'b01,
        FNMT_ST_OPER = 2'b11,
        FNMT_ST_STOP = 2'b10
    } fnmt_state_e;
endpackage

// [verif/fnmt_master.sv]
// partner model: fieldbus master issuing management frames and object writes
`timescale 1ns/1ps
module fnmt_master (
    input wire logic mclk,
    output logic rx_valid,
    output logic [10:0] rx_id,
    output logic rx_ext,
    output logic [3:0] rx_len,
    output logic [7:0] rx_b0,
    output logic [7:0] rx_b1,
    output logic obj_wr,
    output logic [15:0] obj_index,
    output logic [7:0] obj_sub,
    output logic [31:0] obj_data,
    output logic obj_savable,
    output logic save_done
);
    initial begin
        {rx_valid, rx_id, rx_ext, rx_len, rx_b0, rx_b1} = '0;
        {obj_wr, obj_index, obj_sub, obj_data, obj_savable, save_done} = '0;
    end
    // returns just after the edge that samples the frame
    task automatic frame(input logic [10:0] id, input logic ext, input logic [3:0] len,
                         input logic [7:0] b0, input logic [7:0] b1);
        @(posedge mclk);
        rx_valid <= 1'b1;
        rx_id <= id;
        rx_ext <= ext;
        rx_len <= len;
        rx_b0 <= b0;
        rx_b1 <= b1;
        @(posedge mclk);
        rx_valid <= 1'b0;
        // released payload must never look like the last frame
        rx_b0 <= ~b0;
        rx_b1 <= ~b1;
    endtask
    task automatic obj(input logic [15:0] idx, input logic [7:0] sub, input logic sav,
                       input logic [7:0] d0, input logic [7:0] d1, input logic [7:0] d2,
                       input logic [7:0] d3);
        @(posedge mclk);
        obj_wr <= 1'b1;
        obj_index <= idx;
        obj_sub <= sub;
        obj_savable <= sav;
        obj_data <= {d3, d2, d1, d0};
        @(posedge mclk);
        obj_wr <= 1'b0;
        obj_data <= ~{d3, d2, d1, d0};
    endtask
    task automatic done();
        @(posedge mclk);
        save_done <= 1'b1;
        @(posedge mclk);
        save_done <= 1'b0;
    endtask
endmodule

// [verif/tb.sv]
// testbench: management state machine, service gating, identifier map and marker
`timescale 1ns/1ps
module tb;
    import fnmt_pkg::*;
    localparam logic [6:0] NODE = 7'h2A;
    typedef struct {
        logic [7:0] cmd;
        logic [7:0] tgt;
        logic [3:0] len;
        logic [1:0] st;
        logic pdo;
        logic sdo;
    } fnmt_row_s;
    logic mclk, srst, rx_valid, rx_ext, obj_wr, obj_savable, save_done;
    logic [6:0] node_id;
    logic [10:0] rx_id, id_sdo_tx, id_sdo_rx, id_emcy, id_boot;
    logic [3:0] rx_len;
    logic [7:0] rx_b0, rx_b1, obj_sub;
    logic [15:0] obj_index;
    logic [31:0] obj_data, marker_date, marker_time, save_sub1;
    logic [1:0] nmt_state;
    logic [2:0] rx_svc;
    logic [43:0] id_tpdo, id_rpdo;
    logic node_rst_req, comm_rst_req, boot_send, pdo_en, sdo_en, sync_en, emcy_en;
    logic node_ok, rx_hit, save_start;
    int error_cnt = 0, comparisons = 0, cyc = 0, n_node = 0, n_comm = 0, n_boot = 0, n_save = 0;
    fnmt_row_s rows[9] = '{'{8'h01, 8'h00, 4'h2, 2'b11, 1, 1}, '{8'h02, 8'h2A, 4'h2, 2'b10, 0, 0},
        '{8'h01, 8'h2B, 4'h2, 2'b10, 0, 0}, '{8'h80, 8'h00, 4'h2, 2'b01, 0, 1},
        '{8'h03, 8'h00, 4'h2, 2'b01, 0, 1}, '{8'h01, 8'h00, 4'h3, 2'b01, 0, 1},
        '{8'h01, 8'h2A, 4'h2, 2'b11, 1, 1}, '{8'h02, 8'h00, 4'h2, 2'b10, 0, 0},
        '{8'h80, 8'h2A, 4'h2, 2'b01, 0, 1}};

    fnmt_master m (.mclk(mclk), .rx_valid(rx_valid), .rx_id(rx_id), .rx_ext(rx_ext),
        .rx_len(rx_len), .rx_b0(rx_b0), .rx_b1(rx_b1), .obj_wr(obj_wr), .obj_index(obj_index),
        .obj_sub(obj_sub), .obj_data(obj_data), .obj_savable(obj_savable),
        .save_done(save_done));
    fnmt_slave DUT (.mclk(mclk), .srst(srst), .node_id(node_id), .rx_valid(rx_valid),
        .rx_id(rx_id), .rx_ext(rx_ext), .rx_len(rx_len), .rx_b0(rx_b0), .rx_b1(rx_b1),
        .obj_wr(obj_wr), .obj_index(obj_index), .obj_sub(obj_sub), .obj_data(obj_data),
        .obj_savable(obj_savable), .save_done(save_done), .nmt_state(nmt_state),
        .node_rst_req(node_rst_req), .comm_rst_req(comm_rst_req), .boot_send(boot_send),
        .pdo_en(pdo_en), .sdo_en(sdo_en), .sync_en(sync_en), .emcy_en(emcy_en),
        .node_ok(node_ok), .rx_svc(rx_svc), .rx_hit(rx_hit), .id_sdo_tx(id_sdo_tx),
        .id_sdo_rx(id_sdo_rx), .id_emcy(id_emcy), .id_boot(id_boot), .id_tpdo(id_tpdo),
        .id_rpdo(id_rpdo), .marker_date(marker_date), .marker_time(marker_time),
        .save_sub1(save_sub1), .save_start(save_start));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    // -------------------------------------------------------------
    // pulse counters and hang guard
    // -------------------------------------------------------------
    always @(posedge mclk) begin
        cyc++;
        n_node += (node_rst_req === 1'b1);
        n_comm += (comm_rst_req === 1'b1);
        n_boot += (boot_send === 1'b1);
        n_save += (save_start === 1'b1);
        if (cyc == 4000) begin
            error_cnt++;
            close_out();
        end
    end
    task automatic close_out();
        if (error_cnt == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [43:0] exp, input logic [43:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    function automatic logic [10:0] nid(input logic [10:0] base);
        return base + {4'h0, NODE};
    endfunction
    task automatic chk_state(input logic [1:0] st, input logic pdo, input logic sdo);
        repeat (3) @(posedge mclk);
        #1;
        chk("nmt_state", 44'(st), 44'(nmt_state));
        chk("pdo_en", 44'(pdo), 44'(pdo_en));
        chk("sdo_en", 44'(sdo), 44'(sdo_en));
        chk("sync_en", 44'(sdo), 44'(sync_en));
        chk("emcy_en", 44'(sdo), 44'(emcy_en));
    endtask
    task automatic wait_preop();
        int n;
        n = 0;
        while (nmt_state !== 2'b01 && n < 60) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk("preop_reached", 44'h1, 44'(nmt_state === 2'b01));
    endtask
    task automatic svc(input logic [10:0] id, input logic [2:0] exp);
        m.frame(id, 1'b0, 4'h2, 8'h00, 8'h00);
        #1;
        chk("rx_svc", 44'(exp), 44'(rx_svc));
        chk("rx_hit", 44'(exp != 3'd0), 44'(rx_hit));
    endtask

    initial begin
        srst = 1'b1;
        node_id = NODE;
        repeat (12) @(posedge mclk);
        srst <= 1'b0;
        #1;
        chk("nmt_state", 44'h0, 44'(nmt_state));
        chk("save_sub1", 44'h1, 44'(save_sub1));
        wait_preop();
        chk("boots", 44'h1, 44'(n_boot));
        chk("node_ok", 44'h1, 44'(node_ok));
        chk("id_sdo_tx", 44'(nid(11'h580)), 44'(id_sdo_tx));
        chk("id_sdo_rx", 44'(nid(11'h600)), 44'(id_sdo_rx));
        chk("id_emcy", 44'(nid(11'h080)), 44'(id_emcy));
        chk("id_boot", 44'(nid(11'h700)), 44'(id_boot));
        chk("tpdo", {nid(11'h480), nid(11'h380), nid(11'h280), nid(11'h180)}, id_tpdo);
        chk("rpdo", {nid(11'h500), nid(11'h400), nid(11'h300), nid(11'h200)}, id_rpdo);
        foreach (rows[i]) begin
            m.frame(11'h000, 1'b0, rows[i].len, rows[i].cmd, rows[i].tgt);
            chk_state(rows[i].st, rows[i].pdo, rows[i].sdo);
        end
        m.frame(11'h000, 1'b0, 4'h2, 8'h01, 8'h00);
        chk_state(2'b11, 1'b1, 1'b1);
        svc(11'h080, 3'd2);
        svc(nid(11'h600), 3'd3);
        svc(nid(11'h200), 3'd4);
        svc(11'h7FF, 3'd0);
        svc(11'h000, 3'd1);
        m.frame(11'h000, 1'b1, 4'h2, 8'h02, 8'h00);
        chk_state(2'b11, 1'b1, 1'b1);
        m.frame(11'h000, 1'b0, 4'h2, 8'h02, 8'h00);
        chk_state(2'b10, 1'b0, 1'b0);
        svc(nid(11'h600), 3'd0);
        svc(11'h080, 3'd0);
        // a start command during initialization must be lost
        m.frame(11'h000, 1'b0, 4'h2, 8'h81, 8'h2A);
        m.frame(11'h000, 1'b0, 4'h2, 8'h01, 8'h00);
        #1;
        chk("node_rst", 44'h1, 44'(n_node));
        chk("nmt_state", 44'h0, 44'(nmt_state));
        wait_preop();
        chk_state(2'b01, 1'b0, 1'b1);
        m.frame(11'h000, 1'b0, 4'h2, 8'h82, 8'h00);
        chk_state(2'b00, 1'b0, 1'b0);
        chk("comm_rst", 44'h1, 44'(n_comm));
        wait_preop();
        chk("boots", 44'h3, 44'(n_boot));
        m.obj(16'h1020, 8'h01, 1'b1, 8'h44, 8'h33, 8'h22, 8'h11);
        m.obj(16'h1020, 8'h02, 1'b1, 8'h88, 8'h77, 8'h66, 8'h55);
        m.obj(16'h1010, 8'h01, 1'b1, 8'h73, 8'h61, 8'h76, 8'h65);
        @(posedge mclk);
        #1;
        chk("marker_date", 44'h1122_3344, 44'(marker_date));
        chk("marker_time", 44'h5566_7788, 44'(marker_time));
        chk("save_sub1", 44'h6576_6173, 44'(save_sub1));
        chk("save_start", 44'h1, 44'(n_save));
        m.done();
        #1;
        chk("save_sub1", 44'h1, 44'(save_sub1));
        m.obj(16'h6040, 8'h00, 1'b0, 8'h01, 8'h00, 8'h00, 8'h00);
        @(posedge mclk);
        #1;
        chk("marker_date", 44'h1122_3344, 44'(marker_date));
        m.obj(16'h6040, 8'h00, 1'b1, 8'h01, 8'h00, 8'h00, 8'h00);
        @(posedge mclk);
        #1;
        chk("marker_date", 44'h0, 44'(marker_date));
        chk("marker_time", 44'h0, 44'(marker_time));
        // restart by command: the date is kept, the cleared time tells of a change
        m.obj(16'h1020, 8'h01, 1'b1, 8'h44, 8'h33, 8'h22, 8'h11);
        m.frame(11'h000, 1'b0, 4'h2, 8'h81, 8'h00);
        chk_state(2'b00, 1'b0, 1'b0);
        wait_preop();
        chk("marker_date", 44'h1122_3344, 44'(marker_date));
        chk("marker_time", 44'h0, 44'(marker_time));
        // node id zero must not act even on a broadcast
        @(posedge mclk);
        node_id <= 7'h00;
        m.frame(11'h000, 1'b0, 4'h2, 8'h02, 8'h00);
        chk_state(2'b01, 1'b0, 1'b1);
        chk("node_ok", 44'h0, 44'(node_ok));
        close_out();
    end
endmodule
